// ---- design/prt_phy_end.sv ----
// PHY end of the MAC port: RGMII nibbles or SGMII serial on shared pins
`timescale 1ns/10ps
`include "prt_map.svh"
module prt_phy_end #(
	parameter int LINK_SCALE = `PRT_LINK_SCALE,
	parameter int SER_SCALE = `PRT_SER_SCALE
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sgmii_select,
	input wire prt_pkg::prt_speed_e link_speed,
	prt_link_if.phy lk,
	input wire logic [7:0] to_mac_data,
	input wire logic to_mac_valid,
	input wire logic to_mac_error,
	output logic to_mac_ready,
	output logic [7:0] from_mac_data,
	output logic from_mac_valid,
	output logic from_mac_error
);
	// Link rates are scaled down so the sampled model can follow them
	localparam logic [9:0] H_GIG = prt_pkg::prt_half(LINK_SCALE, `PRT_GIG_KHZ);
	localparam logic [9:0] H_FAST = prt_pkg::prt_half(LINK_SCALE, `PRT_FAST_KHZ);
	localparam logic [9:0] H_TEN = prt_pkg::prt_half(LINK_SCALE, `PRT_TEN_KHZ);
	localparam logic [9:0] H_SER = prt_pkg::prt_half(SER_SCALE, `PRT_SER_KHZ);

	prt_pkg::prt_end_s s_reg;
	prt_pkg::prt_end_s s_next;
	logic [9:0] half;
	logic [9:0] mid;
	logic tick_mid;
	logic tick_edge;
	logic rise;
	logic fall;
	logic sbit;

	always_comb begin
		s_next = s_reg;
		to_mac_ready = 1'b0;
		half = H_SER;
		if (s_reg.mode == prt_pkg::PRT_RGMII) begin
			case (link_speed)
				prt_pkg::PRT_TEN: half = H_TEN;
				prt_pkg::PRT_FAST: half = H_FAST;
				prt_pkg::PRT_GIG: half = H_GIG;
				default: half = H_GIG;
			endcase
		end
		mid = half >> 1;
		tick_mid = (s_reg.cnt == mid);
		// Compare with >= so a speed change mid-period cannot stall the divider
		tick_edge = (s_reg.cnt >= half - 10'h001);
		rise = s_reg.ck2 & ~s_reg.ck3;
		fall = ~s_reg.ck2 & s_reg.ck3;
		sbit = s_reg.in2[`PRT_SIN_P];
		s_next.ov = 1'b0;

		// Pins from the MAC cross two flops before use
		s_next.st1 = sgmii_select;
		s_next.st2 = s_reg.st1;
		s_next.ck1 = lk.mac_transmit_clock;
		s_next.ck2 = s_reg.ck1;
		s_next.ck3 = s_reg.ck2;
		s_next.in1 = lk.transmit_nibble;
		s_next.in2 = s_reg.in1;
		s_next.ic1 = lk.transmit_control;
		s_next.ic2 = s_reg.ic1;

		// One divider serves the receive clock or the serial clock
		if (tick_edge) begin
			s_next.cnt = '0;
			s_next.lclk = ~s_reg.lclk;
		end else begin
			s_next.cnt = s_reg.cnt + 10'h001;
		end

		if (s_reg.mode == prt_pkg::PRT_RGMII) begin
			// Data moves mid half-period, so it is centred on each clock edge
			if (tick_mid && !s_reg.lclk) begin
				// A word is taken only ahead of a rising edge; nibbles never split
				s_next.word = '0;
				if (to_mac_valid) begin
					to_mac_ready = 1'b1;
					s_next.word = {to_mac_error, 1'b1, to_mac_data};
				end
				s_next.pin_n = s_next.word[`PRT_LO_NIB];
				s_next.pin_ctl = s_next.word[`PRT_W_DV];
			end else if (tick_mid) begin
				s_next.pin_n = s_reg.word[`PRT_HI_NIB];
				s_next.pin_ctl = s_reg.word[`PRT_W_DV] ^ s_reg.word[`PRT_W_ER];
			end
			s_next.pin_ck = s_next.lclk;

			// Decode the transmit control line on the MAC clock edges
			if (rise) begin
				s_next.lo = s_reg.in2;
				s_next.dv = s_reg.ic2;
			end
			if (fall && s_reg.dv) begin
				s_next.od = {s_reg.in2, s_reg.lo};
				s_next.ov = 1'b1;
				s_next.oe = s_reg.ic2 ^ s_reg.dv;
			end
		end else begin
			// Serial out: start bit, eight data bits, valid, error
			if (tick_mid) begin
				if (s_reg.scnt != 4'h0) begin
					s_next.sout = s_reg.ssh[0];
					s_next.ssh = s_reg.ssh >> 1;
					s_next.scnt = s_reg.scnt - 4'h1;
				end else if (to_mac_valid) begin
					to_mac_ready = 1'b1;
					s_next.sout = ~`PRT_IDLE;
					s_next.ssh = {to_mac_error, 1'b1, to_mac_data};
					s_next.scnt = `PRT_SER_BITS;
				end else begin
					s_next.sout = `PRT_IDLE;
				end
			end

			// Serial in is sampled on every edge of our own serial clock
			if (tick_edge) begin
				case (s_reg.srx)
					prt_pkg::PRT_HUNT: begin
						if (sbit != `PRT_IDLE) begin
							s_next.srx = prt_pkg::PRT_SHIFT;
							s_next.rbits = '0;
						end
					end
					prt_pkg::PRT_SHIFT: begin
						s_next.rsh = {sbit, s_reg.rsh[9:1]};
						s_next.rbits = s_reg.rbits + 4'h1;
						if (s_reg.rbits == `PRT_LAST_BIT) begin
							s_next.srx = prt_pkg::PRT_HUNT;
							s_next.od = s_next.rsh[`PRT_DATA];
							s_next.ov = s_next.rsh[`PRT_W_DV];
							s_next.oe = s_next.rsh[`PRT_W_ER];
						end
					end
					default: s_next.srx = prt_pkg::PRT_HUNT;
				endcase
			end

			// Shared pins carry only the serial functions in this mode
			s_next.pin_n[`PRT_SCK_P] = s_next.lclk;
			s_next.pin_n[`PRT_SCK_N] = ~s_next.lclk;
			s_next.pin_n[`PRT_SOUT_P] = s_next.sout;
			s_next.pin_n[`PRT_SOUT_N] = ~s_next.sout;
			s_next.pin_ck = 1'b0;
			s_next.pin_ctl = 1'b0;
		end

		// Mode strap is caught while reset is held and kept until next reset
		if (rst) begin
			s_next = '0;
			s_next.st1 = sgmii_select;
			s_next.st2 = s_reg.st1;
			s_next.mode = prt_pkg::prt_mode_e'(s_reg.st2);
			s_next.sout = `PRT_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign lk.receive_clock = s_reg.pin_ck;
	assign lk.receive_nibble = s_reg.pin_n;
	assign lk.receive_control = s_reg.pin_ctl;
	assign from_mac_data = s_reg.od;
	assign from_mac_valid = s_reg.ov;
	assign from_mac_error = s_reg.oe;
endmodule

// ---- inc/prt_map.svh ----
// Constants of the RGMII / SGMII MAC port link
// Summary of operation
// - MAC drives four transmit data lines on its clock
// - MAC supplies continuous free-running 125 MHz transmit clock
// - PHY receive clock 2.5, 25 or 125 MHz
// - PHY drives four receive data lines on receive clock
// - Transmit control carries enable and error, both edges
// - Receive control carries valid and error, both edges
// - PHY drives continuous differential 625 MHz serial clock
// - MAC sends serial data on the input pair
// - PHY sends serial data on its clock
`ifndef PRT_MAP_SVH
`define PRT_MAP_SVH
`define PRT_CLK_KHZ 100000
`define PRT_GIG_KHZ 125000
`define PRT_FAST_KHZ 25000
`define PRT_TEN_KHZ 2500
`define PRT_SER_KHZ 625000
`define PRT_LINK_SCALE 20
`define PRT_SER_SCALE 100
`define PRT_SCK_P 0
`define PRT_SCK_N 1
`define PRT_SOUT_P 2
`define PRT_SOUT_N 3
`define PRT_SIN_P 1
`define PRT_SIN_N 0
`define PRT_LO_NIB 3:0
`define PRT_HI_NIB 7:4
`define PRT_DATA 7:0
`define PRT_W_DV 8
`define PRT_W_ER 9
`define PRT_SER_BITS 4'ha
`define PRT_LAST_BIT 4'h9
`define PRT_IDLE 1'b1
`endif

// ---- inc/prt_pkg.sv ----
// Types and divider helper shared by both ends of the MAC port link
`include "prt_map.svh"
package prt_pkg;
	typedef enum logic [1:0] {
		PRT_TEN = 2'b00,
		PRT_FAST = 2'b01,
		PRT_GIG = 2'b10
	} prt_speed_e;
	typedef enum logic {
		PRT_RGMII = 1'b0,
		PRT_SGMII = 1'b1
	} prt_mode_e;
	typedef enum logic {
		PRT_HUNT = 1'b0,
		PRT_SHIFT = 1'b1
	} prt_srx_e;
	typedef struct packed {
		logic st1;
		logic st2;
		prt_mode_e mode;
		logic [9:0] cnt;
		logic lclk;
		logic [9:0] word;
		logic [3:0] pin_n;
		logic pin_ck;
		logic pin_ctl;
		logic [9:0] ssh;
		logic [3:0] scnt;
		logic sout;
		logic ck1;
		logic ck2;
		logic ck3;
		logic [3:0] in1;
		logic [3:0] in2;
		logic ic1;
		logic ic2;
		logic [3:0] lo;
		logic dv;
		prt_srx_e srx;
		logic [3:0] rbits;
		logic [9:0] rsh;
		logic [7:0] od;
		logic ov;
		logic oe;
	} prt_end_s;
	// Half period in clk cycles; rounds down, never below one cycle
	function automatic logic [9:0] prt_half(input int scale, input int khz);
		int c;
		c = `PRT_CLK_KHZ * scale / (2 * khz);
		prt_half = (c < 1) ? 10'h001 : 10'(c);
	endfunction
endpackage

// ---- inc/prt_link_if.sv ----
// Pins between the PHY port and the MAC, shared by RGMII and SGMII
`timescale 1ns/10ps
interface prt_link_if;
	logic mac_transmit_clock;
	logic [3:0] transmit_nibble;
	logic transmit_control;
	logic receive_clock;
	logic [3:0] receive_nibble;
	logic receive_control;
	modport phy (
		input mac_transmit_clock,
		input transmit_nibble,
		input transmit_control,
		output receive_clock,
		output receive_nibble,
		output receive_control
	);
	modport mac (
		output mac_transmit_clock,
		output transmit_nibble,
		output transmit_control,
		input receive_clock,
		input receive_nibble,
		input receive_control
	);
endinterface

// ---- design/prt_mac_end.sv ----
// MAC end of the port link: drives the RGMII transmit clock and both data paths
`timescale 1ns/10ps
`include "prt_map.svh"
module prt_mac_end #(
	parameter int LINK_SCALE = `PRT_LINK_SCALE
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sgmii_select,
	prt_link_if.mac lk,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_error,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_error
);
	localparam logic [9:0] H_GIG = prt_pkg::prt_half(LINK_SCALE, `PRT_GIG_KHZ);

	prt_pkg::prt_end_s s_reg;
	prt_pkg::prt_end_s s_next;
	logic tick_mid;
	logic tick_edge;
	logic rise;
	logic fall;
	logic sbit;

	always_comb begin
		s_next = s_reg;
		tx_ready = 1'b0;
		tick_mid = (s_reg.cnt == (H_GIG >> 1));
		tick_edge = (s_reg.cnt >= H_GIG - 10'h001);
		rise = s_reg.ck2 & ~s_reg.ck3;
		fall = ~s_reg.ck2 & s_reg.ck3;
		sbit = s_reg.in2[`PRT_SOUT_P];
		s_next.ov = 1'b0;

		// The incoming clock is the receive clock or the serial clock
		s_next.st1 = sgmii_select;
		s_next.st2 = s_reg.st1;
		s_next.ck1 = (s_reg.mode == prt_pkg::PRT_SGMII) ?
			lk.receive_nibble[`PRT_SCK_P] : lk.receive_clock;
		s_next.ck2 = s_reg.ck1;
		s_next.ck3 = s_reg.ck2;
		s_next.in1 = lk.receive_nibble;
		s_next.in2 = s_reg.in1;
		s_next.ic1 = lk.receive_control;
		s_next.ic2 = s_reg.ic1;

		// Free-running divider, never gated by traffic
		if (tick_edge) begin
			s_next.cnt = '0;
			s_next.lclk = ~s_reg.lclk;
		end else begin
			s_next.cnt = s_reg.cnt + 10'h001;
		end

		if (s_reg.mode == prt_pkg::PRT_RGMII) begin
			if (tick_mid && !s_reg.lclk) begin
				s_next.word = '0;
				if (tx_valid) begin
					tx_ready = 1'b1;
					s_next.word = {tx_error, 1'b1, tx_data};
				end
				s_next.pin_n = s_next.word[`PRT_LO_NIB];
				s_next.pin_ctl = s_next.word[`PRT_W_DV];
			end else if (tick_mid) begin
				s_next.pin_n = s_reg.word[`PRT_HI_NIB];
				s_next.pin_ctl = s_reg.word[`PRT_W_DV] ^ s_reg.word[`PRT_W_ER];
			end
			s_next.pin_ck = s_next.lclk;
			if (rise) begin
				s_next.lo = s_reg.in2;
				s_next.dv = s_reg.ic2;
			end
			if (fall && s_reg.dv) begin
				s_next.od = {s_reg.in2, s_reg.lo};
				s_next.ov = 1'b1;
				s_next.oe = s_reg.ic2 ^ s_reg.dv;
			end
		end else begin
			// Bits move on each seen edge of the serial clock from the PHY
			if (rise || fall) begin
				if (s_reg.scnt != 4'h0) begin
					s_next.sout = s_reg.ssh[0];
					s_next.ssh = s_reg.ssh >> 1;
					s_next.scnt = s_reg.scnt - 4'h1;
				end else if (tx_valid) begin
					tx_ready = 1'b1;
					s_next.sout = ~`PRT_IDLE;
					s_next.ssh = {tx_error, 1'b1, tx_data};
					s_next.scnt = `PRT_SER_BITS;
				end else begin
					s_next.sout = `PRT_IDLE;
				end
				case (s_reg.srx)
					prt_pkg::PRT_HUNT: begin
						if (sbit != `PRT_IDLE) begin
							s_next.srx = prt_pkg::PRT_SHIFT;
							s_next.rbits = '0;
						end
					end
					prt_pkg::PRT_SHIFT: begin
						s_next.rsh = {sbit, s_reg.rsh[9:1]};
						s_next.rbits = s_reg.rbits + 4'h1;
						if (s_reg.rbits == `PRT_LAST_BIT) begin
							s_next.srx = prt_pkg::PRT_HUNT;
							s_next.od = s_next.rsh[`PRT_DATA];
							s_next.ov = s_next.rsh[`PRT_W_DV];
							s_next.oe = s_next.rsh[`PRT_W_ER];
						end
					end
					default: s_next.srx = prt_pkg::PRT_HUNT;
				endcase
			end
			s_next.pin_n = '0;
			s_next.pin_n[`PRT_SIN_P] = s_next.sout;
			s_next.pin_n[`PRT_SIN_N] = ~s_next.sout;
			s_next.pin_ck = 1'b0;
			s_next.pin_ctl = 1'b0;
		end

		if (rst) begin
			s_next = '0;
			s_next.st1 = sgmii_select;
			s_next.st2 = s_reg.st1;
			s_next.mode = prt_pkg::prt_mode_e'(s_reg.st2);
			s_next.sout = `PRT_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign lk.mac_transmit_clock = s_reg.pin_ck;
	assign lk.transmit_nibble = s_reg.pin_n;
	assign lk.transmit_control = s_reg.pin_ctl;
	assign rx_data = s_reg.od;
	assign rx_valid = s_reg.ov;
	assign rx_error = s_reg.oe;
endmodule

// ---- dv/prt_link_asserts.sv ----
// Link pin checks for the MAC port
`timescale 1ns/10ps
module prt_link_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic sgmii_select,
	input wire prt_pkg::prt_speed_e link_speed,
	input wire logic mac_transmit_clock,
	input wire logic [3:0] transmit_nibble,
	input wire logic transmit_control,
	input wire logic receive_clock,
	input wire logic [3:0] receive_nibble,
	input wire logic receive_control
);
	logic mode_reg;
	logic seen_reg;
	logic rclk_reg;
	logic [1:0] up_reg;
	logic [9:0] rc_reg;
	logic [9:0] half;
	logic rchg;
	assign rchg = receive_clock != rclk_reg;
	assign half = (link_speed == prt_pkg::PRT_GIG) ? 10'h008 :
		(link_speed == prt_pkg::PRT_FAST) ? 10'h028 : 10'h190;
	// Strap trusted only under reset, as both ends latch it there
	always_ff @(posedge clk) begin
		rclk_reg <= receive_clock;
		if (rst) begin
			mode_reg <= sgmii_select;
			seen_reg <= 1'b0;
			up_reg <= 2'h0;
			rc_reg <= 10'h000;
		end else begin
			seen_reg <= seen_reg | rchg;
			up_reg <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
			rc_reg <= rchg ? 10'h000 : rc_reg + 10'h001;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	tclk_half_a: assert property ($changed(mac_transmit_clock) |=>
		$stable(mac_transmit_clock) [*7] ##1 $changed(mac_transmit_clock))
		else $error("tx clock half period wrong");
	rclk_rate_a: assert property (!mode_reg && seen_reg && rchg |->
		rc_reg == half - 10'h001) else $error("rx clock rate wrong");
	sg_quiet_a: assert property (mode_reg |-> !mac_transmit_clock &&
		!transmit_control && !receive_clock && !receive_control)
		else $error("parallel pin active in serial mode");
	sout_pair_a: assert property (mode_reg && up_reg == 2'h3 |->
		receive_nibble[3] == !receive_nibble[2]) else $error("serial out not a pair");
	sck_pair_a: assert property (mode_reg && up_reg == 2'h3 |->
		receive_nibble[1] == !receive_nibble[0]) else $error("serial clock not a pair");
	sck_half_a: assert property (mode_reg && up_reg == 2'h3 &&
		$changed(receive_nibble[0]) |=> $stable(receive_nibble[0]) [*7]
		##1 $changed(receive_nibble[0])) else $error("serial clock half wrong");
	sin_pair_a: assert property (mode_reg && up_reg == 2'h3 |->
		transmit_nibble[0] == !transmit_nibble[1] && transmit_nibble[3:2] == 2'h0)
		else $error("serial in pins wrong");
	tdata_hold_a: assert property (!mode_reg && $changed(mac_transmit_clock) |->
		($stable(transmit_nibble) && $stable(transmit_control)) [*4])
		else $error("tx data moved at clock edge");
	rdata_hold_a: assert property (!mode_reg && $changed(receive_clock) |->
		($stable(receive_nibble) && $stable(receive_control)) [*4])
		else $error("rx data moved at clock edge");
	tidle_ctl_a: assert property (!mode_reg && $rose(mac_transmit_clock) &&
		!transmit_control |-> transmit_nibble == 4'h0 ##8 !transmit_control)
		else $error("idle tx half not quiet");
	cover property (!mode_reg && $rose(mac_transmit_clock) && transmit_control);
	cover property (mode_reg && $fell(receive_nibble[2]));
	cover property (!mode_reg && link_speed == prt_pkg::PRT_TEN && $rose(receive_control));
endmodule

// ---- dv/prt_link_tb.sv ----
// Bench: both ends joined by the link, random bytes each way
`timescale 1ns/10ps
module phy_rgmii_sgmii_mac_port_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sg = 1'b0;
	prt_pkg::prt_speed_e spd = prt_pkg::PRT_GIG;
	logic [1:0] vv = 2'b00;
	logic [1:0] ee = 2'b00;
	logic [7:0] dd [2] = '{8'h00, 8'h00};
	wire [1:0] rr;
	logic [7:0] fd;
	logic [7:0] rd;
	logic fv, fe, rv, re;
	logic [8:0] q [2][$];
	logic [8:0] qw [$];
	logic pclk = 1'b0;
	logic wf = 1'b0;
	logic [3:0] lo_nib = 4'h0;
	int mismatches = 0;
	int compares = 0;
	int cyc = 0;
	prt_link_if lk ();
	prt_mac_end u_prt_mac_end (.clk(clk), .rst(rst), .sgmii_select(sg), .lk(lk.mac),
		.tx_data(dd[0]), .tx_valid(vv[0]), .tx_error(ee[0]), .tx_ready(rr[0]),
		.rx_data(rd), .rx_valid(rv), .rx_error(re));
	prt_phy_end u_prt_phy_end (.clk(clk), .rst(rst), .sgmii_select(sg), .link_speed(spd),
		.lk(lk.phy), .to_mac_data(dd[1]), .to_mac_valid(vv[1]), .to_mac_error(ee[1]),
		.to_mac_ready(rr[1]), .from_mac_data(fd), .from_mac_valid(fv), .from_mac_error(fe));
	prt_link_asserts u_prt_link_asserts (.clk(clk), .rst(rst), .sgmii_select(sg),
		.link_speed(spd), .mac_transmit_clock(lk.mac_transmit_clock),
		.transmit_nibble(lk.transmit_nibble), .transmit_control(lk.transmit_control),
		.receive_clock(lk.receive_clock), .receive_nibble(lk.receive_nibble),
		.receive_control(lk.receive_control));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Next word queued at the sending end, unknown if nothing was sent
	function automatic logic [8:0] next_exp(input int k);
		logic [8:0] w;
		w = 9'hxxx;
		if (q[k].size() > 0)
			w = q[k].pop_front();
		return w;
	endfunction
	task automatic report_and_stop;
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Word held until ready, then queued as expected at the far end
	task automatic send(input int k, input logic [8:0] w);
		int n = 0;
		dd[k] = w[7:0];
		ee[k] = w[8];
		vv[k] = 1'b1;
		#1;
		while (rr[k] !== 1'b1 && n < 3000) begin
			@(negedge clk);
			#1;
			n++;
		end
		q[k].push_back(w);
		if (k == 0)
			qw.push_back(w);
		@(negedge clk);
	endtask
	task automatic traffic(input int k, input int n);
		send(k, 9'h0ff);
		send(k, 9'h100);
		repeat (n) send(k, 9'($urandom));
		vv[k] = 1'b0;
	endtask
	always @(negedge clk) begin
		if (rst)
			wf = 1'b0;
		else if (!sg && lk.mac_transmit_clock !== pclk) begin
			if (lk.mac_transmit_clock === 1'b1) begin
				wf = lk.transmit_control;
				lo_nib = lk.transmit_nibble;
			end else if (wf === 1'b1) begin
				chk({~lk.transmit_control, lk.transmit_nibble, lo_nib}, qw.pop_front());
			end
		end
		pclk = lk.mac_transmit_clock;
		if (!rst && fv === 1'b1)
			chk({fe, fd}, next_exp(0));
		if (!rst && rv === 1'b1)
			chk({re, rd}, next_exp(1));
	end
	// Hang guard, well above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			$display("ERROR %0t: timeout", $time);
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(16153));
		// Phases: ten, fast, gig parallel, then serial
		for (int ph = 0; ph < 4; ph++) begin
			rst = 1'b1;
			sg = (ph == 3);
			spd = prt_pkg::prt_speed_e'(2'((ph == 3) ? 2 : ph));
			qw.delete();
			repeat (5) @(negedge clk);
			rst = 1'b0;
			fork
				traffic(0, (ph == 0) ? 4 : 16);
				traffic(1, (ph == 0) ? 4 : 16);
			join
			for (int i = 0; i < 2000 && q[0].size() + q[1].size() > 0; i++)
				@(negedge clk);
			chk(9'(q[0].size() + q[1].size()), 9'h000);
		end
		report_and_stop();
	end
endmodule
